// *** hbc_regs.vh ***
// hbc_regs.vh: constants for the bridge mode and protection controller
// assumes a 250 MHz core clock; all times converted to cycles here
`ifndef HBC_REGS_VH
`define HBC_REGS_VH
`define HBC_CLK_MHZ          250
`define HBC_SLEEP_TIME_MS    10
`define HBC_SLEEP_CYC        (`HBC_SLEEP_TIME_MS * 1000 * `HBC_CLK_MHZ)
`define HBC_DEG_TIME_US      4
`define HBC_DEG_CYC          (`HBC_DEG_TIME_US * `HBC_CLK_MHZ)
`define HBC_RETRY_TIME_US    2000
`define HBC_RETRY_CYC        (`HBC_RETRY_TIME_US * `HBC_CLK_MHZ)
`define HBC_MODE_STBY        2'h0
`define HBC_MODE_REV         2'h1
`define HBC_MODE_FWD         2'h2
`define HBC_MODE_BRAKE       2'h3
`define HBC_SW_OFF           4'h0
`define HBC_SW_FWD           4'h9
`define HBC_SW_REV           4'h6
`define HBC_SW_BRAKE         4'h5
`define HBC_OE_OFF           2'h0
`endif

// *** hbc_sync.v ***
// hbc_sync.v: three-stage synchroniser with agreement filter per bit
// assumes inputs asynchronous to clock; output changes when stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none
module hbc_sync #(
	parameter W = 1,
	parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst_n,
	// data
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] s1_r;
	reg [W-1:0] s2_r;
	reg [W-1:0] s3_r;
	genvar i;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n)
					q[i] <= RST_VAL[i];
				else if (s2_r[i] == s3_r[i])
					q[i] <= s3_r[i];
			end
		end
	endgenerate
endmodule // hbc_sync
`default_nettype wire

// *** hbc_timer.v ***
// hbc_timer.v: down-counting interval timer with load and clear
// assumes a single clock; done is a level while count is zero after a load
`timescale 1ns/1ps
`default_nettype none
module hbc_timer #(
	parameter W = 24
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst_n,
	// control
	input  wire         load,
	input  wire         clear,
	input  wire [W-1:0] len,
	// status
	output reg          busy,
	output wire         done
);
	reg [W-1:0] cnt_r;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= {W{1'b0}};
			busy  <= 1'b0;
		end else if (clear) begin
			cnt_r <= {W{1'b0}};
			busy  <= 1'b0;
		end else if (load) begin
			cnt_r <= len;
			busy  <= 1'b1;
		end else if (busy && cnt_r != {W{1'b0}}) begin
			cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
		end
	end
	assign done = busy && (cnt_r == {W{1'b0}});
endmodule // hbc_timer
`default_nettype wire

// *** hbc_bridge_ctrl.v ***
// hbc_bridge_ctrl.v: full-bridge mode decode, sleep entry and fault protection
// assumes fault indications come from analog comparators (asynchronous);
// control inputs come from host timer pins, pull-downs modelled as default 0.
`timescale 1ns/1ps
`default_nettype none
`include "hbc_regs.vh"
module hbc_bridge_ctrl #(
	parameter integer SLEEP_CYC = `HBC_SLEEP_CYC,
	parameter integer DEG_CYC   = `HBC_DEG_CYC,
	parameter integer RETRY_CYC = `HBC_RETRY_CYC,
	parameter integer TW        = 22
) (
	// clock and reset
	input  wire       clock,
	input  wire       rst_n,
	// control inputs from host drive pins
	input  wire       ctrl_in_a,
	input  wire       ctrl_in_b,
	// analog fault indications
	input  wire       supply_low_lockout,
	input  wire       overcurrent_guard,
	input  wire       short_circuit_guard,
	input  wire       over_temp_hi,
	input  wire       over_temp_lo,
	// bridge switch gates
	output reg        high_side_a,
	output reg        low_side_a,
	output reg        high_side_b,
	output reg        low_side_b,
	// bridge output pins
	output reg        bridge_out_a,
	output reg        bridge_out_a_oe,
	output reg        bridge_out_b,
	output reg        bridge_out_b_oe,
	// status
	output reg        sleep_state,
	output reg        fault_active,
	output reg        analog_enable
);
	// active period states
	localparam [2:0] ST_RUN   = 3'h0;
	localparam [2:0] ST_DEG   = 3'h1;
	localparam [2:0] ST_OCRET = 3'h2;
	localparam [2:0] ST_SCRET = 3'h3;
	localparam [2:0] ST_SCCHK = 3'h4;

	function [3:0] sw_of_mode;
		input [1:0] m;
		begin
			case (m)
				`HBC_MODE_FWD:   sw_of_mode = `HBC_SW_FWD;
				`HBC_MODE_REV:   sw_of_mode = `HBC_SW_REV;
				`HBC_MODE_BRAKE: sw_of_mode = `HBC_SW_BRAKE;
				default:         sw_of_mode = `HBC_SW_OFF;
			endcase
		end
	endfunction

	// one leg's pin as {enable, level}; hi-z unless a switch of that leg is on
	function [1:0] pin_of_leg;
		input [1:0] hl;
		begin
			case (hl)
				2'h2:    pin_of_leg = 2'h3;
				2'h1:    pin_of_leg = 2'h2;
				default: pin_of_leg = 2'h0;
			endcase
		end
	endfunction

	// a leg that changes side in one step would short the supply through slow turn-off
	function leg_swaps;
		input [1:0] want;
		input [1:0] now;
		begin
			leg_swaps = (want[1] && now[0]) || (want[0] && now[1]);
		end
	endfunction

	// bit positions in the synchronised input word
	localparam integer SY_A  = 6;
	localparam integer SY_B  = 5;
	localparam integer SY_UV = 4;
	localparam integer SY_OC = 3;
	localparam integer SY_SC = 2;
	localparam integer SY_TH = 1;
	localparam integer SY_TL = 0;

	// comparators arrive unsynchronised too, so they share the input filter
	wire [6:0] raw_in = {ctrl_in_a, ctrl_in_b, supply_low_lockout, overcurrent_guard,
		short_circuit_guard, over_temp_hi, over_temp_lo};
	wire [6:0] syn;
	// pull-downs: inputs reset to 0, so floating pins read as standby
	hbc_sync #(.W(7), .RST_VAL(7'h00)) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (raw_in),
		.q     (syn)
	);
	wire [1:0] mode     = {syn[SY_A], syn[SY_B]};
	wire       uv       = syn[SY_UV];
	wire       oc       = syn[SY_OC];
	wire       sc       = syn[SY_SC];
	wire       t_hi     = syn[SY_TH];
	wire       t_lo     = syn[SY_TL];
	wire       stby     = (mode == `HBC_MODE_STBY);

	// thermal latch: hysteresis from two thresholds
	// the hot level wins when both thresholds move in one cycle
	reg        ot_r;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ot_r <= 1'b0;
		else if (t_hi)
			ot_r <= 1'b1;
		else if (!t_lo)
			ot_r <= 1'b0;
	end

	// sleep entry counter
	// counter parks at the limit, so a long standby cannot wrap it
	reg [TW-1:0] slp_cnt_r;
	reg          sleep_r;
	wire [TW-1:0] slp_lim = SLEEP_CYC[TW-1:0];
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			slp_cnt_r <= {TW{1'b0}};
			sleep_r   <= 1'b0;
		end else if (!stby) begin
			slp_cnt_r <= {TW{1'b0}};
			sleep_r   <= 1'b0;
		end else if (!sleep_r) begin
			if (slp_cnt_r == slp_lim)
				sleep_r <= 1'b1;
			else
				slp_cnt_r <= slp_cnt_r + {{(TW-1){1'b0}}, 1'b1};
		end
	end
	// sleep only escapes on a 1, so 11 brake from sleep also wakes
	// wake taken straight from the inputs: protection covers the first active cycle
	wire awake = !(sleep_r && stby);

	// protection group gating
	wire act_prot = awake && !stby;

	// timer load/clear
	// one timer serves de-glitch and retry; they never run together
	reg [2:0]    st_r;
	reg [2:0]    st_nxt;
	reg          t_load;
	reg [TW-1:0] t_len;
	wire         t_busy;
	wire         t_done;
	wire         t_clear = !act_prot;
	hbc_timer #(.W(TW)) u_tmr (
		.clock (clock),
		.rst_n (rst_n),
		.load  (t_load),
		.clear (t_clear),
		.len   (t_len),
		.busy  (t_busy),
		.done  (t_done)
	);

	always @* begin
		st_nxt = st_r;
		t_load = 1'b0;
		t_len  = RETRY_CYC[TW-1:0];
		case (st_r)
			ST_RUN: begin
				if (sc) begin
					st_nxt = ST_SCRET;
					t_load = 1'b1;
				end else if (oc) begin
					st_nxt = ST_DEG;
					t_load = 1'b1;
					t_len  = DEG_CYC[TW-1:0];
				end
			end
			ST_DEG: begin
				if (sc) begin
					st_nxt = ST_SCRET;
					t_load = 1'b1;
				end else if (!oc) begin
					st_nxt = ST_RUN; // glitch rejected
				end else if (t_done) begin
					st_nxt = ST_OCRET;
					t_load = 1'b1;
				end
			end
			ST_OCRET: begin
				if (t_done)
					st_nxt = ST_RUN;
			end
			ST_SCRET: begin
				if (t_done)
					st_nxt = ST_SCCHK;
			end
			ST_SCCHK: begin
				// one probe cycle with switches on to re-test the short
				if (sc) begin
					st_nxt = ST_SCRET;
					t_load = 1'b1;
				end else begin
					st_nxt = ST_RUN;
				end
			end
			default: st_nxt = ST_RUN;
		endcase
		if (!act_prot) begin
			st_nxt = ST_RUN;
			t_load = 1'b0;
		end
	end

	// fault state
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			st_r <= ST_RUN;
		else
			st_r <= st_nxt;
	end

	// lockout: comparator already has 1.5/1.8 V hysteresis
	wire uv_lock   = act_prot && uv;
	wire       oc_off    = (st_r == ST_OCRET);
	wire       sc_off    = (st_r == ST_SCRET);
	wire [3:0] flt_vec   = {uv_lock, oc_off, sc_off, ot_r};
	wire       any_fault = |flt_vec;
	wire [3:0] sw_req    = any_fault ? `HBC_SW_OFF : sw_of_mode(mode);
	// all switches rest one cycle when a leg changes side; costs a cycle on reversal
	wire       gap       = leg_swaps(sw_req[3:2], {high_side_a, low_side_a}) ||
		leg_swaps(sw_req[1:0], {high_side_b, low_side_b});
	wire [3:0] sw        = gap ? `HBC_SW_OFF : sw_req;
	wire [1:0] pin_a     = pin_of_leg(sw[3:2]);
	wire [1:0] pin_b     = pin_of_leg(sw[1:0]);

	// switch gates
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			high_side_a <= 1'b0;
			low_side_a  <= 1'b0;
			high_side_b <= 1'b0;
			low_side_b  <= 1'b0;
		end else begin
			high_side_a <= sw[3];
			low_side_a  <= sw[2];
			high_side_b <= sw[1];
			low_side_b  <= sw[0];
		end
	end

	// output pins; sleep shows standby because sw is off there
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bridge_out_a    <= 1'b0;
			bridge_out_a_oe <= 1'b0;
			bridge_out_b    <= 1'b0;
			bridge_out_b_oe <= 1'b0;
		end else begin
			bridge_out_a_oe <= pin_a[1];
			bridge_out_a    <= pin_a[0];
			bridge_out_b_oe <= pin_b[1];
			bridge_out_b    <= pin_b[0];
		end
	end

	// status
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sleep_state   <= 1'b0;
			fault_active  <= 1'b0;
			analog_enable <= 1'b0;
		end else begin
			sleep_state   <= !awake;
			fault_active  <= any_fault;
			analog_enable <= awake;
		end
	end
endmodule // hbc_bridge_ctrl
`default_nettype wire

// *** hbc_monitor.sv ***
// hbc_monitor.sv: port assertions for the bridge controller
// assumes one clock and async active-low reset; sees top ports only
`timescale 1ns/1ps
`default_nettype none
module hbc_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// inputs
	input wire logic ctrl_in_a,
	input wire logic supply_low_lockout,
	input wire logic over_temp_hi,
	// outputs
	input wire logic high_side_a,
	input wire logic low_side_a,
	input wire logic high_side_b,
	input wire logic low_side_b,
	input wire logic bridge_out_a,
	input wire logic bridge_out_a_oe,
	input wire logic bridge_out_b,
	input wire logic bridge_out_b_oe,
	input wire logic sleep_state,
	input wire logic analog_enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire on = high_side_a | low_side_a | high_side_b | low_side_b;
	// eight samples cover the input synchroniser delay
	a_no_shoot: assert property (!(high_side_a && low_side_a) && !(high_side_b && low_side_b))
		else $error("shoot-through on a bridge leg");
	a_oe_pair: assert property (bridge_out_a_oe == bridge_out_b_oe)
		else $error("bridge enables disagree");
	a_on_driven: assert property (on |-> bridge_out_a_oe)
		else $error("switch on with hi-z pin");
	a_out_a: assert property (bridge_out_a_oe |-> bridge_out_a == high_side_a)
		else $error("pin a level wrong");
	a_out_b: assert property (bridge_out_b_oe |-> bridge_out_b == high_side_b)
		else $error("pin b level wrong");
	a_sleep_off: assert property (sleep_state |-> !analog_enable && !on && !bridge_out_a_oe)
		else $error("activity while sleeping");
	a_therm_off: assert property (over_temp_hi [*8] |-> !on)
		else $error("hot die with switch on");
	a_uv_hiz: assert property (supply_low_lockout [*8] |-> !bridge_out_a_oe && !on)
		else $error("pins driven in lockout");
	a_wake_fast: assert property (ctrl_in_a [*8] |-> !sleep_state)
		else $error("sleep kept with input high");
	a_leg_gap: assert property (!(high_side_a && $past(low_side_a)) &&
		!(low_side_a && $past(high_side_a)) && !(high_side_b && $past(low_side_b)) &&
		!(low_side_b && $past(high_side_b)))
		else $error("leg changed side with no rest cycle");
endmodule // hbc_monitor
bind hbc_bridge_ctrl hbc_monitor i_mon (.clock, .rst_n, .ctrl_in_a, .supply_low_lockout,
	.over_temp_hi, .high_side_a, .low_side_a, .high_side_b, .low_side_b, .bridge_out_a,
	.bridge_out_a_oe, .bridge_out_b, .bridge_out_b_oe, .sleep_state, .analog_enable);
`default_nettype wire

// *** hbc_host_model.sv ***
// hbc_host_model.sv: host timer pins feeding the bridge inputs
// assumes commands change after a rising edge; unconfigured pins read low
`timescale 1ns/1ps
`default_nettype none
module hbc_host_model (
	input wire logic       clock,
	input wire logic       cfg_out,
	input wire logic [1:0] cmd,
	output var logic       ctrl_in_a,
	output var logic       ctrl_in_b
);
	initial {ctrl_in_a, ctrl_in_b} = 2'h0;
	// pins only drive once set as outputs, else the pull-downs win
	always @(posedge clock) begin
		{ctrl_in_a, ctrl_in_b} <= cfg_out ? cmd : 2'h0;
	end
endmodule // hbc_host_model
`default_nettype wire

// *** hbc_bridge_ctrl_test.sv ***
// hbc_bridge_ctrl_test.sv: self-checking bench for the bridge controller
// assumes short sim intervals: sleep 50, de-glitch 4, retry 20 cycles
`timescale 1ns/1ps
`default_nettype none
module hbc_bridge_ctrl_test;
	logic clock = 0, rst_n = 0, cfg = 0, uv = 0, oc = 0, sc = 0, th = 0, tl = 0;
	logic [1:0] cmd = 2'h0;
	wire ia, ib, hsa, lsa, hsb, lsb, pa, pae, pb, pbe, slp, flt, aen;
	wire [3:0] sw = {hsa, lsa, hsb, lsb};
	wire [3:0] pin = {pae, pbe, pa, pb};
	integer n_errors = 0, n_tests = 0, m;
	logic [3:0] e_sw[4] = '{4'h0, 4'h6, 4'h9, 4'h5};
	logic [3:0] e_pin[4] = '{4'h0, 4'hd, 4'he, 4'hc};
	hbc_host_model i_host (.clock(clock), .cfg_out(cfg), .cmd(cmd), .ctrl_in_a(ia),
		.ctrl_in_b(ib));
	hbc_bridge_ctrl #(.SLEEP_CYC(50), .DEG_CYC(4), .RETRY_CYC(20)) i_dut (.clock(clock),
		.rst_n(rst_n), .ctrl_in_a(ia), .ctrl_in_b(ib), .supply_low_lockout(uv),
		.overcurrent_guard(oc), .short_circuit_guard(sc), .over_temp_hi(th),
		.over_temp_lo(tl), .high_side_a(hsa), .low_side_a(lsa), .high_side_b(hsb),
		.low_side_b(lsb), .bridge_out_a(pa), .bridge_out_a_oe(pae), .bridge_out_b(pb),
		.bridge_out_b_oe(pbe), .sleep_state(slp), .fault_active(flt), .analog_enable(aen));
	initial begin
		forever #2 clock = ~clock;
	end
	task wt(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task chk(input [3:0] g, input [3:0] e);
		n_tests = n_tests + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task go(input [1:0] c);
		@(posedge clock) cmd <= c;
		wt(8);
	endtask
	task t_modes;
		go(2'h2);
		chk(sw, 4'h0);
		@(posedge clock) cfg <= 1'b1;
		for (m = 0; m < 4; m = m + 1) begin
			go(m[1:0]);
			chk(sw, e_sw[m]);
			chk(pin, e_pin[m]);
		end
		$display("modes done");
	endtask
	task t_sleep;
		go(2'h0);
		wt(32);
		chk({3'h0, slp}, 4'h0);
		@(posedge clock) cmd <= 2'h3;
		wt(2);
		go(2'h0);
		wt(32);
		chk({3'h0, slp}, 4'h0);
		wt(20);
		chk({2'h0, slp, aen}, 4'h2);
		@(posedge clock) {uv, oc, sc} <= 3'h7;
		wt(10);
		chk({3'h0, flt}, 4'h0);
		@(posedge clock) {uv, oc, sc} <= 3'h0;
		go(2'h2);
		chk({sw[3:1], slp}, 4'h8);
		$display("sleep done");
	endtask
	task t_uv;
		@(posedge clock) uv <= 1'b1;
		wt(8);
		chk(sw | pin, 4'h0);
		@(posedge clock) uv <= 1'b0;
		wt(8);
		chk(sw, 4'h9);
		@(posedge clock) uv <= 1'b1;
		wt(8);
		chk(sw, 4'h0);
		@(posedge clock) uv <= 1'b0;
		wt(8);
		$display("uv done");
	endtask
	task t_oc;
		@(posedge clock) oc <= 1'b1;
		wt(2);
		@(posedge clock) oc <= 1'b0;
		wt(16);
		chk(sw, 4'h9);
		@(posedge clock) oc <= 1'b1;
		wt(7);
		chk(sw, 4'h9);
		wt(8);
		chk({flt, sw[2:0]}, 4'h8);
		@(posedge clock) oc <= 1'b0;
		wt(10);
		chk(sw, 4'h0);
		wt(20);
		chk(sw, 4'h9);
		$display("oc done");
	endtask
	task t_sc;
		@(posedge clock) sc <= 1'b1;
		wt(7);
		chk(sw, 4'h0);
		wt(30);
		@(posedge clock) sc <= 1'b0;
		wt(30);
		chk(sw, 4'h9);
		$display("sc done");
	endtask
	task t_therm;
		go(2'h0);
		@(posedge clock) {th, tl} <= 2'h3;
		wt(8);
		chk({3'h0, flt}, 4'h1);
		go(2'h2);
		chk(sw, 4'h0);
		@(posedge clock) th <= 1'b0;
		wt(8);
		chk(sw, 4'h0);
		@(posedge clock) tl <= 1'b0;
		wt(8);
		chk(sw, 4'h9);
		$display("therm done");
	endtask
	task give_verdict;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#100000;
		n_errors = n_errors + 1;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_modes;
		t_sleep;
		t_uv;
		t_oc;
		t_sc;
		t_therm;
		give_verdict;
	end
endmodule // hbc_bridge_ctrl_test
`default_nettype wire
